// ===== arf_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Conversion core: shows a code one cycle after a request and scrambles its lines while idle.
module arf_core_model
(
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic        sign_in,
   input  wire logic [11:0] data_in,
   output var  logic        conv_valid,
   output var  logic        conv_sign,
   output var  logic [11:0] conv_data
);
   initial begin
      conv_valid = 1'b0;
      conv_sign  = 1'b0;
      conv_data  = 12'h000;
   end

   always @(posedge clk) begin
      conv_valid <= req;
      conv_sign  <= req ? sign_in : ~conv_sign;
      conv_data  <= req ? data_in : ~conv_data;
   end
endmodule

`default_nettype wire

// ===== arf_formatter.sv
// Function
// RULE1: Control bit 10 set gives 12-bit results, clear gives 10-bit results.
// RULE2: Unsigned formats hold 12 or 10 magnitude bits and no sign bit.
// RULE3: Signed formats add a sign bit, giving 13 or 11 bits.
// RULE4: Signed results copy the sign bit into every higher word bit.
// RULE5: Control bits 9:8 choose the output format.
// RULE6: 12-bit layouts: integer, signed integer, fractional, signed fractional as specified.
// RULE7: Unsigned integer output is zero for negative codes, positive codes unchanged.
// RULE8: Signed integer output is the two's-complement code, -4096 to +4095.
// RULE9: Format codes 0..3 map int, signed int, frac, signed frac; 10-bit mirrors.
`timescale 1ns/1ps
`default_nettype none

module arf_formatter
   import arf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [CTRL_W-1:0] converter_control_one,
   input  wire logic              conv_valid,
   input  wire logic              conv_sign,
   input  wire logic [DATA_W-1:0] conv_data,
   input  wire logic              rd_en,
   input  wire logic [BUF_AW-1:0] rd_addr,
   output var  logic [WORD_W-1:0] rd_data,
   output var  logic              rd_valid,
   output var  logic [WORD_W-1:0] last_result,
   output var  logic              result_valid,
   output var  logic [BUF_AW-1:0] write_index
);

   logic              resolution_select;
   arf_format_t       output_format_select;
   logic [WORD_W-1:0] word;
   logic [WORD_W-1:0] next_last_result;
   logic              next_result_valid;
   logic              next_rd_valid;
   logic [BUF_AW-1:0] next_write_index;

   // The code from the conversion core is two's complement: the sign bit
   // sits directly above the data bits that the resolution uses.
   // Negative codes in the two unsigned formats give zero, as those formats cannot carry a sign.
   function automatic logic [WORD_W-1:0] arf_format(
      input logic              res12,
      input arf_format_t       fmt,
      input logic              sign,
      input logic [DATA_W-1:0] data
   );
      logic [WORD_W-1:0] w;
      w = RESULT_RST;
      if (res12) begin                                                   // see RULE1
         case (fmt)
            ARF_FMT_INT:   w = sign ? RESULT_RST : {4'h0, data};        // see RULE6 see RULE7 see RULE2
            ARF_FMT_SINT:  w = {{3{sign}}, sign, data};                 // see RULE8 see RULE4 see RULE3
            ARF_FMT_FRAC:  w = sign ? RESULT_RST : {data, 4'h0};        // see RULE6 see RULE2
            ARF_FMT_SFRAC: w = {sign, data, 3'h0};                      // see RULE6 see RULE3
            default:       w = RESULT_RST;
         endcase
      end else begin
         case (fmt)
            ARF_FMT_INT:   w = sign ? RESULT_RST : {6'h00, data[9:0]};  // see RULE9 see RULE2
            ARF_FMT_SINT:  w = {{5{sign}}, sign, data[9:0]};            // see RULE9 see RULE4 see RULE3
            ARF_FMT_FRAC:  w = sign ? RESULT_RST : {data[9:0], 6'h00};  // see RULE9 see RULE2
            ARF_FMT_SFRAC: w = {sign, data[9:0], 5'h00};                // see RULE9 see RULE3
            default:       w = RESULT_RST;
         endcase
      end
      return w;
   endfunction

   assign resolution_select    = converter_control_one[CTRL_RES_BIT];                      // see RULE1
   assign output_format_select = arf_format_t'(converter_control_one[CTRL_FMT_LSB +: 2]);  // see RULE5
   assign word = arf_format(resolution_select, output_format_select, conv_sign, conv_data);

   always_comb begin
      next_last_result  = last_result;
      next_write_index  = write_index;
      next_result_valid = 1'b0;
      next_rd_valid     = rd_en;
      if (conv_valid) begin
         next_last_result  = word;
         next_write_index  = write_index + PTR_STEP;
         next_result_valid = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         last_result  <= RESULT_RST;
         write_index  <= PTR_RST;
         result_valid <= 1'b0;
         rd_valid     <= 1'b0;
      end else begin
         last_result  <= next_last_result;
         write_index  <= next_write_index;
         result_valid <= next_result_valid;
         rd_valid     <= next_rd_valid;
      end
   end

   // A conversion writes the buffer and advances the write index on the same edge.
   // The index wraps after the last entry, so the oldest word is overwritten without notice.
   arf_result_ram u_ram (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (conv_valid),
      .wr_addr (write_index),
      .wr_data (word),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // Every check below runs on the system clock and sleeps while reset is held.
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   logic       res_q;
   logic [1:0] fmt_q;

   assign res_q = converter_control_one[CTRL_RES_BIT];
   assign fmt_q = converter_control_one[CTRL_FMT_LSB +: 2];

   res_select_a: assert property (                                                    // see RULE1
      conv_valid && !conv_sign && fmt_q == 2'h0
      |=> last_result == ($past(res_q) ? {4'h0, $past(conv_data)}
                                       : {6'h00, $past(conv_data[9:0])}))
      else $error("Resolution select does not set the result width.");

   unsigned_width_a: assert property (                                                // see RULE2
      conv_valid && !res_q && fmt_q == 2'h0 |=> last_result[15:10] == 6'h00)
      else $error("Unsigned 10-bit integer has bits above bit 9 set.");

   signed10_ext_a: assert property (                                                  // see RULE3
      conv_valid && !res_q && fmt_q == 2'h1
      |=> last_result == {{5{$past(conv_sign)}}, $past(conv_sign), $past(conv_data[9:0])})
      else $error("Signed 10-bit integer is not an 11-bit extended value.");

   sign_fill_a: assert property (                                                     // see RULE4
      conv_valid && res_q && fmt_q == 2'h1
      ##1 result_valid |-> last_result[15:12] == {4{$past(conv_sign)}})
      else $error("Sign bit not copied into bits 15:12.");

   format_field_a: assert property (                                                  // see RULE5
      conv_valid && res_q && fmt_q == 2'h2 && !conv_sign
      |=> last_result[3:0] == 4'h0 && last_result[15:4] == $past(conv_data))
      else $error("Format field does not pick the fractional layout.");

   sfrac12_layout_a: assert property (                                                // see RULE6
      conv_valid && res_q && fmt_q == 2'h3
      |=> last_result == {$past(conv_sign), $past(conv_data), 3'h0})
      else $error("Signed fractional 12-bit layout is wrong.");

   unsigned_clamp_a: assert property (                                                // see RULE7
      conv_valid && conv_sign && !fmt_q[0] |=> last_result == 16'h0000)
      else $error("Negative code not clamped to zero in unsigned format.");

   signed_int_a: assert property (                                                    // see RULE8
      conv_valid && res_q && fmt_q == 2'h1
      |=> $signed(last_result) == $signed({$past(conv_sign), $past(conv_data)}))
      else $error("Signed integer is not the two's-complement code.");

   sfrac10_mirror_a: assert property (                                                // see RULE9
      conv_valid && !res_q && fmt_q == 2'h3
      |=> last_result == {$past(conv_sign), $past(conv_data[9:0]), 5'h00})
      else $error("Signed fractional 10-bit layout is wrong.");

   result_pulse_a: assert property (
      conv_valid |=> result_valid && write_index == $past(write_index) + 4'h1)
      else $error("Result strobe or write index did not follow a conversion.");

   read_stored_a: assert property (
      conv_valid ##1 (rd_en && rd_addr == $past(write_index)) |=> rd_valid && rd_data == $past(last_result))
      else $error("Buffer read does not return the stored word.");

   // Strobes and registered outputs move only when their request arrives, so a
   // stray change between conversions or reads is caught here.
   result_strobe_a: assert property (
      !conv_valid |=> !result_valid)
      else $error("Result strobe raised without a conversion.");

   result_hold_a: assert property (
      !conv_valid |=> $stable(last_result) && $stable(write_index))
      else $error("Result or write index changed without a conversion.");

   read_strobe_a: assert property (
      rd_en |=> rd_valid)
      else $error("Read strobe missing after a read request.");

   read_idle_a: assert property (
      !rd_en |=> !rd_valid && $stable(rd_data))
      else $error("Read strobe or read data changed without a request.");

   // Layout checks that the width and format checks above leave open.
   int12_top_a: assert property (                                                     // see RULE2
      conv_valid && res_q && fmt_q == 2'h0 |=> last_result[15:12] == 4'h0)
      else $error("Unsigned 12-bit integer has bits above bit 11 set.");

   frac10_mirror_a: assert property (                                                 // see RULE9
      conv_valid && !res_q && fmt_q == 2'h2 && !conv_sign
      |=> last_result == {$past(conv_data[9:0]), 6'h00})
      else $error("Fractional 10-bit layout is wrong.");

   sint10_fill_a: assert property (                                                   // see RULE4
      conv_valid && !res_q && fmt_q == 2'h1 |=> last_result[15:10] == {6{$past(conv_sign)}})
      else $error("Sign bit not copied into bits 15:10.");

   sfrac_sign_a: assert property (                                                    // see RULE3
      conv_valid && fmt_q == 2'h3 |=> last_result[15] == $past(conv_sign))
      else $error("Signed fractional sign bit is not in bit 15.");

   // Main scenarios that the bench should reach.
   negative_int_c:   cover property (conv_valid && conv_sign && fmt_q == 2'h0);
   signed_frac_c:    cover property (conv_valid && fmt_q == 2'h3 ##1 rd_en);
   ten_bit_signed_c: cover property (conv_valid && !res_q && fmt_q == 2'h1);
   back_to_back_c:   cover property (conv_valid [*3]);
   ten_bit_frac_c:   cover property (conv_valid && !res_q && fmt_q == 2'h2);

endmodule

`default_nettype wire

// ===== arf_pkg.sv
`default_nettype none

package arf_pkg;

   localparam int unsigned WORD_W       = 16;
   localparam int unsigned DATA_W       = 12;
   localparam int unsigned CTRL_W       = 16;
   localparam int unsigned BUF_AW       = 4;
   localparam int unsigned BUF_DEPTH    = 16;

   // Field positions inside converter_control_one.
   localparam int unsigned CTRL_RES_BIT = 10;
   localparam int unsigned CTRL_FMT_LSB = 8;

   // Values after reset, and the write index step.
   localparam logic [15:0] RESULT_RST   = 16'h0000;
   localparam logic [3:0]  PTR_RST      = 4'h0;
   localparam logic [3:0]  PTR_STEP     = 4'h1;

   typedef enum logic [1:0] {
      ARF_FMT_INT   = 2'h0,
      ARF_FMT_SINT  = 2'h1,
      ARF_FMT_FRAC  = 2'h2,
      ARF_FMT_SFRAC = 2'h3
   } arf_format_t;

endpackage

`default_nettype wire

// ===== arf_result_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Result buffer with one write port and one registered read port.
// A read and a write to the same entry in one cycle return the old word.
module arf_result_ram
   import arf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              wr_en,
   input  wire logic [BUF_AW-1:0] wr_addr,
   input  wire logic [WORD_W-1:0] wr_data,
   input  wire logic              rd_en,
   input  wire logic [BUF_AW-1:0] rd_addr,
   output var  logic [WORD_W-1:0] rd_data
);

   logic [WORD_W-1:0] mem [BUF_DEPTH];
   logic [WORD_W-1:0] next_rd_data;

   always_comb begin
      next_rd_data = rd_data;
      if (rd_en) begin
         next_rd_data = mem[rd_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= RESULT_RST;
      end else begin
         rd_data <= next_rd_data;
      end
   end

endmodule

`default_nettype wire

// ===== tb_adc_result_formatter.sv
`timescale 1ns/1ps
`default_nettype none

module tb_adc_result_formatter;
   import arf_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] ctrl_q = 16'h0000;
   logic [15:0] ctrl = 16'h0000;
   logic        req = 1'b0;
   logic        s_in = 1'b0;
   logic [11:0] d_in = 12'h000;
   logic        rd_en = 1'b0;
   logic [3:0]  rd_addr = 4'h0;
   logic        cv, cs, rv, res_v;
   logic [11:0] cd;
   logic [15:0] rdat, last;
   logic [3:0]  widx, wp = 4'h0, nw = 4'h0;
   logic [15:0] eq[$], rq[$], mem[16];
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   int          seed = 87338;

   arf_core_model i_core (.clk(clk), .req(req), .sign_in(s_in), .data_in(d_in),
                          .conv_valid(cv), .conv_sign(cs), .conv_data(cd));
   arf_formatter i_dut (.clk(clk), .rst(rst), .converter_control_one(ctrl), .conv_valid(cv),
                        .conv_sign(cs), .conv_data(cd), .rd_en(rd_en), .rd_addr(rd_addr),
                        .rd_data(rdat), .rd_valid(rv), .last_result(last), .result_valid(res_v),
                        .write_index(widx));

   initial forever #5 clk = ~clk;

   // Control follows the core's one-cycle delay so it matches the code it formats.
   always @(posedge clk) ctrl <= ctrl_q;

   function automatic logic [15:0] fmt_word(input logic [15:0] c, input logic s, input logic [11:0] d);
      logic [9:0] t;
      t = d[9:0];
      if (c[10]) begin
         case (c[9:8])
            2'h0: return s ? 16'h0000 : {4'h0, d};
            2'h1: return {{4{s}}, d};
            2'h2: return s ? 16'h0000 : {d, 4'h0};
            default: return {s, d, 3'h0};
         endcase
      end
      case (c[9:8])
         2'h0: return s ? 16'h0000 : {6'h00, t};
         2'h1: return {{6{s}}, t};
         2'h2: return s ? 16'h0000 : {t, 6'h00};
         default: return {s, t, 5'h00};
      endcase
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic conv(input logic [15:0] c, input logic s, input logic [11:0] d);
      @(posedge clk);
      ctrl_q <= c;
      req    <= 1'b1;
      s_in   <= s;
      d_in   <= d;
      eq.push_back(fmt_word(c, s, d));
      mem[wp] = fmt_word(c, s, d);
      wp++;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         conclude();
      end
      if (!rst && res_v === 1'b1) begin
         chk(last, eq.pop_front());
         chk({12'h000, widx}, {12'h000, nw + 4'h1});
         nw = nw + 4'h1;
      end
      if (!rst && rv === 1'b1) chk(rdat, rq.pop_front());
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({12'h000, widx}, 16'h0000);
      chk(last, RESULT_RST);
      chk(rdat, RESULT_RST);
      for (int m = 0; m < 8; m++) begin
         for (int k = 0; k < 4; k++) begin
            conv({5'h00, m[2], m[1:0], 8'h00}, k[0], k[1] ? 12'hFFF : 12'h000);
         end
      end
      for (int i = 0; i < 40; i++) begin
         conv(16'($random(seed)), 1'($random(seed)), 12'($random(seed)));
      end
      @(posedge clk);
      req <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         @(posedge clk);
         rd_en   <= 1'b1;
         rd_addr <= 4'(a);
         rq.push_back(mem[a]);
      end
      @(posedge clk);
      rd_en <= 1'b0;
      // Read an entry in the cycle right after the conversion lands in it.
      conv(16'h0700, 1'b1, 12'h123);
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      rd_en   <= 1'b1;
      rd_addr <= wp - 4'h1;
      rq.push_back(mem[wp - 4'h1]);
      @(posedge clk);
      rd_en <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(eq.size() + rq.size()), 16'h0000);
      conclude();
   end
endmodule

`default_nettype wire
